//--- scbo_pkg.sv
// package for the switched-cap block output control register bank
package scbo_pkg;
  localparam int unsigned NUM_BLOCKS = 4;
  localparam int unsigned REG_W = 8;
  localparam int unsigned ADDR_W = 10;
  // printed offsets are not all multiples of four: offsets are indices, byte address = 4*index
  localparam logic [7:0] IDX_A_CTRL1 = 8'h85;
  localparam logic [7:0] IDX_A_CTRL2 = 8'h86;
  localparam logic [7:0] IDX_B_CTRL1 = 8'h8D;
  localparam logic [7:0] IDX_B_CTRL2 = 8'h8E;
  localparam logic [7:0] IDX_C_CTRL1 = 8'h91;
  localparam logic [7:0] IDX_C_CTRL2 = 8'h92;
  localparam logic [7:0] IDX_D_CTRL1 = 8'h99;
  localparam logic [7:0] IDX_D_CTRL2 = 8'h9A;
  // own registers: phase select and feedback flag per block, bus state per block
  localparam logic [7:0] IDX_PHASE_CFG = 8'hA0;
  localparam logic [7:0] IDX_STATUS = 8'hA1;
  localparam int unsigned BIT_COL_BUS = 7;
  localparam int unsigned BIT_CMP_BUS = 6;
  localparam int unsigned BIT_AZ = 5;
  localparam int unsigned CAP_MSB = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // phase sequencer: ticks per phase, dead tick between phases, late window of phase two
  localparam logic [3:0] PHASE_TICKS = 4'h4;
  localparam logic [3:0] LATE_TICK = 4'h2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [3:0] {
    SCBO_P1 = 4'b0001,
    SCBO_GAP1 = 4'b0010,
    SCBO_P2 = 4'b0100,
    SCBO_GAP2 = 4'b1000
  } scbo_phase_t;

  typedef struct packed {
    logic col_bus_en;
    logic col_bus_oe_n;
    logic cmp_bus_out;
    logic short_sw;
    logic in_to_gnd;
    logic in_to_amp;
    logic sum_pair_sw;
    logic fb_sw;
    logic [4:0] cap_size;
  } scbo_sw_t;
endpackage : scbo_pkg

//--- scbo_ctrl.sv
// register bank and switch sequencing for four switched-cap output stages
// Functional notes
// - bus enable clear: column output high impedance
// - phase bit clear: drive late second phase
// - phase bit set: drive column continuously
// - bit 6 enables comparator bus drive
// - undriven comparator bus reads low
// - comparator sampled at first phase rise, held
// - auto-zero: short in phase one, inputs sequenced
// - auto-zero clear: switch open, inputs to amp
// - auto-zero activates summing node switch pair
// - low five bits: C capacitor unit count
// - bits 7,6,5 fields; all RW, reset zero
// - four instances, same address both banks
// - feedback switch gated by flag and auto-zero
`timescale 1ns/1ps
`default_nettype none
module scbo_ctrl #(
  parameter int unsigned BLOCKS = scbo_pkg::NUM_BLOCKS
) (
  input wire logic REF_CLK_IN, // 25 MHz clock
  input wire logic RST_IN, // async reset, active high
  input wire logic HSEL_IN, // ahb slave select
  input wire logic [31:0] HADDR_IN, // ahb address
  input wire logic [1:0] HTRANS_IN, // ahb transfer type
  input wire logic HWRITE_IN, // ahb write
  input wire logic [2:0] HSIZE_IN, // ahb size
  input wire logic [31:0] HWDATA_IN, // ahb write data
  input wire logic HREADY_IN, // ahb bus ready
  output logic [31:0] HRDATA_OUT, // ahb read data
  output logic HREADYOUT_OUT, // ahb slave ready
  output logic HRESP_OUT, // ahb response, always okay
  input wire logic [3:0] CMP_RESULT_IN, // comparator outputs, asynchronous
  output logic FIRST_PHASE_OUT, // first internal phase
  output logic SECOND_PHASE_OUT, // second internal phase
  output var scbo_pkg::scbo_sw_t [3:0] SW_OUT, // per block switch controls
  output logic [3:0] CMP_BUS_OUT // column comparator bus level
);
  typedef struct packed {
    logic [3:0][7:0] ctrl_one;
    logic [3:0][7:0] ctrl_two;
    logic [7:0] phase_cfg;
    scbo_pkg::scbo_phase_t phase;
    logic [3:0] tick;
    logic [3:0] cmp_sync1;
    logic [3:0] cmp_sync2;
    logic [3:0] cmp_latch;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    scbo_pkg::scbo_sw_t [3:0] sw;
    logic p1;
    logic p2;
  } scbo_state_t;

  scbo_state_t st_reg;
  scbo_state_t st_next;

  // idle switch set: column released, inputs on the amplifier, nothing shorted
  localparam scbo_pkg::scbo_sw_t SW_IDLE = '{
    col_bus_en: 1'b0,
    col_bus_oe_n: 1'b1,
    cmp_bus_out: 1'b0,
    short_sw: 1'b0,
    in_to_gnd: 1'b0,
    in_to_amp: 1'b1,
    sum_pair_sw: 1'b0,
    fb_sw: 1'b0,
    cap_size: 5'h00
  };

  // maps a control-two index to its block, or none
  function automatic logic [2:0] ctrl_two_block(input logic [7:0] idx);
    unique case (idx)
      scbo_pkg::IDX_A_CTRL2: ctrl_two_block = 3'h0;
      scbo_pkg::IDX_B_CTRL2: ctrl_two_block = 3'h1;
      scbo_pkg::IDX_C_CTRL2: ctrl_two_block = 3'h2;
      scbo_pkg::IDX_D_CTRL2: ctrl_two_block = 3'h3;
      default: ctrl_two_block = 3'h4;
    endcase
  endfunction : ctrl_two_block

  function automatic logic [2:0] ctrl_one_block(input logic [7:0] idx);
    unique case (idx)
      scbo_pkg::IDX_A_CTRL1: ctrl_one_block = 3'h0;
      scbo_pkg::IDX_B_CTRL1: ctrl_one_block = 3'h1;
      scbo_pkg::IDX_C_CTRL1: ctrl_one_block = 3'h2;
      scbo_pkg::IDX_D_CTRL1: ctrl_one_block = 3'h3;
      default: ctrl_one_block = 3'h4;
    endcase
  endfunction : ctrl_one_block

  logic addr_ph;
  logic [7:0] a_idx;
  logic [2:0] b1;
  logic [2:0] b2;
  logic [2:0] rb1;
  logic [2:0] rb2;
  logic late_p2;
  logic [7:0] status_v;

  assign addr_ph = HSEL_IN && HREADY_IN && (HTRANS_IN == scbo_pkg::HTRANS_NONSEQ);
  // byte address is four times the register index; bank bit is not decoded
  assign a_idx = HADDR_IN[scbo_pkg::ADDR_W-1:2];
  assign b1 = ctrl_one_block(st_reg.wr_idx);
  assign b2 = ctrl_two_block(st_reg.wr_idx);
  assign rb1 = ctrl_one_block(a_idx);
  assign rb2 = ctrl_two_block(a_idx);

  always_comb begin
    status_v = {st_reg.cmp_latch, CMP_BUS_OUT};
    st_next = st_reg;
    st_next.cmp_sync1 = CMP_RESULT_IN;
    st_next.cmp_sync2 = st_reg.cmp_sync1;
    // write data phase
    st_next.wr_pend = 1'b0;
    if (st_reg.wr_pend) begin
      if (b2 != 3'h4) begin
        st_next.ctrl_two[b2[1:0]] = HWDATA_IN[scbo_pkg::REG_W-1:0];
      end else if (b1 != 3'h4) begin
        st_next.ctrl_one[b1[1:0]] = HWDATA_IN[scbo_pkg::REG_W-1:0];
      end else if (st_reg.wr_idx == scbo_pkg::IDX_PHASE_CFG) begin
        st_next.phase_cfg = HWDATA_IN[scbo_pkg::REG_W-1:0];
      end
    end
    if (addr_ph) begin
      st_next.wr_pend = HWRITE_IN;
      st_next.wr_idx = a_idx;
      st_next.rdata = 32'h0000_0000;
      // read after the pending write, so a back-to-back read sees the new value
      if (!HWRITE_IN) begin
        if (rb2 != 3'h4) begin
          st_next.rdata = {24'h00_0000, st_next.ctrl_two[rb2[1:0]]};
        end else if (rb1 != 3'h4) begin
          st_next.rdata = {24'h00_0000, st_next.ctrl_one[rb1[1:0]]};
        end else if (a_idx == scbo_pkg::IDX_PHASE_CFG) begin
          st_next.rdata = {24'h00_0000, st_next.phase_cfg};
        end else if (a_idx == scbo_pkg::IDX_STATUS) begin
          st_next.rdata = {24'h00_0000, status_v};
        end
      end
    end
    // phase sequencer with a dead tick between phases
    st_next.tick = st_reg.tick + 4'h1;
    unique case (st_reg.phase)
      scbo_pkg::SCBO_P1: begin
        if (st_reg.tick == scbo_pkg::PHASE_TICKS - 4'h1) begin
          st_next.phase = scbo_pkg::SCBO_GAP1;
          st_next.tick = 4'h0;
        end
      end
      scbo_pkg::SCBO_GAP1: begin
        st_next.phase = scbo_pkg::SCBO_P2;
        st_next.tick = 4'h0;
      end
      scbo_pkg::SCBO_P2: begin
        if (st_reg.tick == scbo_pkg::PHASE_TICKS - 4'h1) begin
          st_next.phase = scbo_pkg::SCBO_GAP2;
          st_next.tick = 4'h0;
        end
      end
      scbo_pkg::SCBO_GAP2: begin
        st_next.phase = scbo_pkg::SCBO_P1;
        st_next.tick = 4'h0;
        st_next.cmp_latch = st_reg.cmp_sync2; // sampled as first phase rises
      end
      default: begin
        st_next.phase = scbo_pkg::SCBO_GAP2;
        st_next.tick = 4'h0;
      end
    endcase
    st_next.p1 = (st_next.phase == scbo_pkg::SCBO_P1);
    st_next.p2 = (st_next.phase == scbo_pkg::SCBO_P2);
    // late window taken from the phase being entered, so it lines up with the phase output
    late_p2 = (st_next.phase == scbo_pkg::SCBO_P2) && (st_next.tick >= scbo_pkg::LATE_TICK);
    for (int i = 0; i < 4; i++) begin
      logic [7:0] c;
      logic az;
      logic fsel;
      logic fflag;
      c = st_reg.ctrl_two[i];
      az = c[scbo_pkg::BIT_AZ];
      fsel = st_reg.phase_cfg[i];
      fflag = st_reg.phase_cfg[i + scbo_pkg::NUM_BLOCKS];
      // column bus: off, late second phase, or continuous
      st_next.sw[i].col_bus_en = c[scbo_pkg::BIT_COL_BUS] && (fsel || late_p2);
      st_next.sw[i].col_bus_oe_n = !st_next.sw[i].col_bus_en;
      st_next.sw[i].cmp_bus_out = c[scbo_pkg::BIT_CMP_BUS] && st_reg.cmp_latch[i];
      st_next.sw[i].short_sw = az && st_next.p1;
      st_next.sw[i].in_to_gnd = az && st_next.p1;
      st_next.sw[i].in_to_amp = !az || st_next.p2;
      st_next.sw[i].sum_pair_sw = az;
      st_next.sw[i].fb_sw = fflag && (!az || st_next.p2);
      st_next.sw[i].cap_size = c[scbo_pkg::CAP_MSB:0];
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_reg <= '0; // all control registers clear at power-on, phase set to the second gap
      st_reg.phase <= scbo_pkg::SCBO_GAP2;
      st_reg.sw <= {4{SW_IDLE}}; // column released, inputs on amp
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      // no driver in the column leaves the bus low
      CMP_BUS_OUT[i] = st_reg.sw[i].cmp_bus_out;
    end
  end

  assign HRDATA_OUT = st_reg.rdata;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;
  assign FIRST_PHASE_OUT = st_reg.p1;
  assign SECOND_PHASE_OUT = st_reg.p2;
  assign SW_OUT = st_reg.sw;
endmodule : scbo_ctrl
`default_nettype wire

//--- scbo_ctrl_sva.sv
// checker for the switched-cap output control block
`timescale 1ns/1ps
`default_nettype none
module scbo_ctrl_sva (
  input wire logic REF_CLK_IN, // clock
  input wire logic RST_IN, // async reset
  input wire logic FIRST_PHASE_OUT, // phase one
  input wire logic SECOND_PHASE_OUT, // phase two
  input wire scbo_pkg::scbo_sw_t [3:0] SW_OUT // switch controls
);
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (RST_IN);
  sequence s_one;
    FIRST_PHASE_OUT [*4] ##1 (!FIRST_PHASE_OUT && !SECOND_PHASE_OUT);
  endsequence
  sequence s_two;
    SECOND_PHASE_OUT [*4] ##1 (!SECOND_PHASE_OUT && !FIRST_PHASE_OUT);
  endsequence
  chk_phase_order: assert property ($rose(FIRST_PHASE_OUT) |-> s_one ##1 s_two)
    else $error("phase sequence wrong");
  chk_phase_apart: assert property (!(FIRST_PHASE_OUT && SECOND_PHASE_OUT))
    else $error("phases overlap");
  chk_short_phase: assert property (SW_OUT[0].short_sw |-> !SECOND_PHASE_OUT)
    else $error("short switch in phase two");
  chk_gnd_phase: assert property (SW_OUT[0].in_to_gnd |-> !SECOND_PHASE_OUT)
    else $error("inputs grounded in phase two");
  chk_input_paths: assert property (SW_OUT[0].in_to_gnd |-> !SW_OUT[0].in_to_amp)
    else $error("input both ground and amp");
  chk_az_off_open: assert property (!SW_OUT[0].sum_pair_sw |->
    !SW_OUT[0].short_sw && !SW_OUT[0].in_to_gnd) else $error("switch active without az");
  chk_fb_az_phase: assert property (SW_OUT[0].fb_sw && SW_OUT[0].sum_pair_sw
    |-> !FIRST_PHASE_OUT) else $error("feedback closed in phase one");
  chk_drive_needs_en: assert property (!SW_OUT[0].col_bus_oe_n |-> SW_OUT[0].col_bus_en)
    else $error("column driven while disabled");
  chk_amp_phase_two: assert property (SW_OUT[0].sum_pair_sw |->
    (SW_OUT[0].in_to_amp == SECOND_PHASE_OUT)) else $error("amp path not in phase two");
  chk_az_off_amp: assert property (!SW_OUT[0].sum_pair_sw |-> SW_OUT[0].in_to_amp)
    else $error("inputs off amp without az");
  chk_short_phase_one: assert property (SW_OUT[0].sum_pair_sw && FIRST_PHASE_OUT |->
    SW_OUT[0].short_sw && SW_OUT[0].in_to_gnd) else $error("short missing in phase one");
endmodule : scbo_ctrl_sva
bind scbo_ctrl scbo_ctrl_sva u_sva (.REF_CLK_IN, .RST_IN, .FIRST_PHASE_OUT,
  .SECOND_PHASE_OUT, .SW_OUT);
`default_nettype wire

//--- switched_cap_block_output_control_tb.sv
// register-level testbench for the switched-cap output control block
`timescale 1ns/1ps
`default_nettype none
module switched_cap_block_output_control_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] cmp = 4'h0;
  logic [31:0] hrdata, rd, a, b, c, f1, f2;
  logic hready, hresp, ph1, ph2;
  logic [3:0] cbus;
  scbo_pkg::scbo_sw_t [3:0] sw;
  int fail_count = 0;
  int checks_done = 0;
  logic [7:0] ctl2 [4] = '{8'h86, 8'h8E, 8'h92, 8'h9A};
  initial forever #20 clk = ~clk;
  scbo_ctrl dut (.REF_CLK_IN(clk), .RST_IN(rst), .HSEL_IN(1'b1), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .CMP_RESULT_IN(cmp), .FIRST_PHASE_OUT(ph1), .SECOND_PHASE_OUT(ph2), .SW_OUT(sw),
    .CMP_BUS_OUT(cbus));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d,
    output logic [31:0] r);
    @(posedge clk);
    haddr <= {22'h0, i, 2'h0};
    hwrite <= w;
    htrans <= scbo_pkg::HTRANS_NONSEQ;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask : xfer
  // counts column drive, short and feedback cycles of block a over one period
  task automatic span();
    a = 0;
    b = 0;
    c = 0;
    f1 = 0;
    f2 = 0;
    repeat (2) @(posedge clk);
    repeat (10) begin
      @(negedge clk);
      a += 32'(!sw[0].col_bus_oe_n);
      b += 32'(sw[0].short_sw);
      c += 32'(sw[0].fb_sw);
      f1 += 32'(ph1);
      f2 += 32'(ph2);
    end
  endtask : span
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b0, ctl2[k], 8'h00, rd);
      chk(rd, 32'h0);
    end
    chk(32'(hresp), 32'h0);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, ctl2[k], 8'hE0 | 8'(k), rd);
      xfer(1'b1, ctl2[k] - 8'h1, 8'h55, rd);
    end
    for (int k = 0; k < 4; k++) begin
      xfer(1'b0, ctl2[k], 8'h00, rd);
      chk(rd, 32'hE0 | 32'(k));
    end
    xfer(1'b0, 8'h85, 8'h00, rd);
    chk(rd, 32'h55);
    xfer(1'b1, 8'h00, 8'hFF, rd);
    xfer(1'b0, 8'h00, 8'h00, rd);
    chk(rd, 32'h0);
    xfer(1'b1, 8'h86, 8'h1F, rd);
    span();
    chk(32'(sw[0].cap_size), 32'h1F);
    chk(f1, 32'd4);
    chk(f2, 32'd4);
    xfer(1'b1, 8'h86, 8'h00, rd);
    span();
    chk(a, 32'd0);
    xfer(1'b1, 8'h86, 8'h80, rd);
    span();
    chk(a, 32'd2);
    xfer(1'b1, 8'hA0, 8'h01, rd);
    span();
    chk(a, 32'd10);
    @(posedge clk);
    cmp <= 4'h1;
    xfer(1'b1, 8'h86, 8'h40, rd);
    span();
    chk(32'(cbus[0]), 32'h1);
    xfer(1'b0, 8'hA1, 8'h00, rd);
    chk(rd, 32'h11);
    xfer(1'b1, 8'h86, 8'h00, rd);
    span();
    chk(32'(cbus[0]), 32'h0);
    xfer(1'b1, 8'hA0, 8'h10, rd);
    xfer(1'b1, 8'h86, 8'h20, rd);
    span();
    chk(b, 32'd4);
    chk(c, 32'd4);
    chk(32'(sw[0].sum_pair_sw), 32'h1);
    xfer(1'b1, 8'h86, 8'h00, rd);
    span();
    chk(b, 32'd0);
    chk(c, 32'd10);
    // reset again in mid-run: registers and switches must return to their idle state
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    xfer(1'b0, 8'h86, 8'h00, rd);
    chk(rd, 32'h0);
    @(negedge clk);
    chk(32'(sw[0].col_bus_oe_n), 32'h1);
    chk(32'(sw[0].in_to_amp), 32'h1);
    print_verdict();
  end
endmodule : switched_cap_block_output_control_tb
`default_nettype wire
